// >>> shared/wwdst_map.svh
// Constants of the windowed watchdog: offsets, fields, reset values, timing
`ifndef WWDST_MAP_SVH
`define WWDST_MAP_SVH

// ==========================================
// Clock and timing
`define WWDST_CLK_NS 100
`define WWDST_TICK_NS 550000
`define WWDST_TICK_CYC ((`WWDST_TICK_NS) / (`WWDST_CLK_NS))
`define WWDST_FILT_NS 32000
`define WWDST_FILT_CYC (((`WWDST_FILT_NS) + (`WWDST_CLK_NS) - 1) / (`WWDST_CLK_NS))
`define WWDST_PULSE_NS 40000
`define WWDST_PULSE_CYC (((`WWDST_PULSE_NS) + (`WWDST_CLK_NS) - 1) / (`WWDST_CLK_NS))

// ==========================================
// Window settings and fail tally
`define WWDST_WIN1_W 7
`define WWDST_WIN2_W 5
`define WWDST_WIN1_RST 7'h0A
`define WWDST_WIN2_RST 5'h05
`define WWDST_TALLY_INIT 3'h5
`define WWDST_TALLY_MAX 3'h7

// ==========================================
// Watchdog flag register fields
`define WWDST_FLAG_EARLY 0
`define WWDST_FLAG_TIMEOUT 1

// ==========================================
// Host Wishbone register offsets (byte addresses)
`define WWDST_REG_TRIG 8'h00
`define WWDST_REG_WIN1 8'h04
`define WWDST_REG_WIN2 8'h08
`define WWDST_REG_STAT 8'h0C
`define WWDST_REG_FRAME 8'h10
`define WWDST_STAT_BUSY 5
`define WWDST_STAT_TALLY 2

`endif

// >>> shared/wwdst_pkg.sv
// Types shared by both ends of the windowed watchdog
package wwdst_pkg;
    typedef enum logic [1:0] {
        SEQ_RESTART,
        SEQ_CLOSED,
        SEQ_OPEN
    } wwdst_seq_t;

    typedef enum logic [1:0] {
        PUL_IDLE,
        PUL_HIGH,
        PUL_LOW
    } wwdst_pulse_t;
endpackage

// >>> shared/wwdst_if.sv
// Link between the supervised controller and the watchdog sequencer
`timescale 1ns/1ps
`include "wwdst_map.svh"
interface wwdst_if;
    logic fault_trigger_input;
    logic ncs_n;
    logic cfg_wr;
    logic cfg_sel;
    logic [`WWDST_WIN1_W-1:0] cfg_data;
    logic [1:0] flag_clr;
    logic [1:0] watchdog_flag_reg;
    logic [2:0] fail_tally;

    modport dev (
        input fault_trigger_input, ncs_n, cfg_wr, cfg_sel, cfg_data, flag_clr,
        output watchdog_flag_reg, fail_tally
    );
    modport host (
        output fault_trigger_input, ncs_n, cfg_wr, cfg_sel, cfg_data, flag_clr,
        input watchdog_flag_reg, fail_tally
    );
endinterface

// >>> core/wwdst_device.sv
// Windowed watchdog sequencer: closed/open windows, trigger filter, fail tally
//
// Summary of operation
// - Sequence is closed window then open window
// - Window lengths writable only in diagnostic state
// - Closed window spans first_window_ticks ticks
// - Open window spans setting plus one ticks
// - Derive 0.55 ms tick from system clock
// - Time-out after both windows without event
// - Time-out sets flag, bumps tally, restarts
// - Frame active at time-out suppresses flag
// - Next sequence starts one clock later
// - Any window write restarts and bumps tally
// - Accepted setting applies from new sequence
// - Good, bad, time-out, power events restart
// - Trigger mode from fault_trigger_input by default
// - Trigger is high longer than 32 us
// - Deglitch filter on system clock qualifies trigger
// - Trigger in closed window: bad, early flag
// - Trigger in open window: good, restart
// - Controller triggers early enough in open window
// - Reset on failure only when allowed
// - Controller uses window settings two or more; the bench writes an open window setting of 1
// - Controller aims trigger at open window midpoint
// - Tally down on good, up on bad
// - Tally loaded with five on state entry
`timescale 1ns/1ps
`include "wwdst_map.svh"
module wwdst_device #(
    parameter int TICK_CYC = `WWDST_TICK_CYC,
    parameter int FILT_CYC = `WWDST_FILT_CYC,
    parameter logic [`WWDST_WIN1_W-1:0] WIN1_RST = `WWDST_WIN1_RST,
    parameter logic [`WWDST_WIN2_W-1:0] WIN2_RST = `WWDST_WIN2_RST
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link to the supervised controller
    wwdst_if.dev link,
    // Device state and configuration
    input wire logic diag_state_i,
    input wire logic diag_to_active_i,
    input wire logic config_lock_command_i,
    input wire logic fail_reset_allow_i,
    input wire logic power_event_i,
    // Outputs to the device
    output logic out_of_range_o,
    output logic force_reset_o,
    output logic good_event_o,
    output logic bad_event_o,
    output logic timeout_event_o
);

    // ==========================================
    // Elaboration checks
    generate
        if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_bad_tick
            $error("TICK_CYC out of range");
        end
        if (FILT_CYC < 1 || FILT_CYC > 65535) begin : g_bad_filt
            $error("FILT_CYC out of range");
        end
    endgenerate

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);
    localparam logic [15:0] FILT_LAST = 16'(FILT_CYC - 1);

    wwdst_pkg::wwdst_seq_t seq;
    logic [`WWDST_WIN1_W-1:0] closed_window_length_reg;
    logic [`WWDST_WIN2_W-1:0] open_window_length_reg;
    logic [`WWDST_WIN1_W-1:0] first_window_ticks;
    logic [`WWDST_WIN2_W-1:0] open_ticks;
    logic [15:0] prescale;
    logic [7:0] win_count;
    logic tick;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_level;
    logic [15:0] filt_count;
    logic trig_pulse;
    logic good;
    logic bad;
    logic timeout;
    logic restart;
    logic [1:0] flags;
    logic [2:0] tally;

    // ==========================================
    // Trigger deglitch filter
    // Three-stage synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= link.fault_trigger_input;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // The filtered level follows only after the agreed input holds FILT_CYC cycles,
    // so a high shorter than the filter time never forms a pulse.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_level <= 1'b0;
            filt_count <= 16'h0000;
        end else if (trig_s2 != trig_s3 || trig_s3 == trig_level) begin
            filt_count <= 16'h0000;
        end else if (filt_count == FILT_LAST) begin
            trig_level <= trig_s3;
            filt_count <= 16'h0000;
        end else begin
            filt_count <= filt_count + 16'h0001;
        end
    end

    // Falling edge of a qualified high forms the watchdog pulse
    assign trig_pulse = trig_level && trig_s2 == trig_s3 && !trig_s3 && filt_count == FILT_LAST;

    // ==========================================
    // Event classification
    assign good = seq == wwdst_pkg::SEQ_OPEN && trig_pulse;
    assign bad = seq == wwdst_pkg::SEQ_CLOSED && trig_pulse;
    assign timeout = seq == wwdst_pkg::SEQ_OPEN && !trig_pulse && tick
        && win_count == {3'h0, open_ticks};
    assign restart = good || bad || timeout || link.cfg_wr || power_event_i;

    // ==========================================
    // Window configuration
    // Writes land only in the diagnostic state and while unlocked; the write still
    // restarts the sequence and bumps the tally, so a blocked write only resynchronises and bumps the tally.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            closed_window_length_reg <= WIN1_RST;
            open_window_length_reg <= WIN2_RST;
        end else if (link.cfg_wr && diag_state_i && !config_lock_command_i) begin
            if (link.cfg_sel) begin
                open_window_length_reg <= link.cfg_data[`WWDST_WIN2_W-1:0];
            end else begin
                closed_window_length_reg <= link.cfg_data;
            end
        end
    end

    // ==========================================
    // Tick prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i || seq == wwdst_pkg::SEQ_RESTART || restart) begin
            prescale <= 16'h0000;
        end else if (prescale == TICK_LAST) begin
            prescale <= 16'h0000;
        end else begin
            prescale <= prescale + 16'h0001;
        end
    end

    assign tick = prescale == TICK_LAST;

    // ==========================================
    // Sequence state machine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq <= wwdst_pkg::SEQ_RESTART;
            win_count <= 8'h00;
            first_window_ticks <= WIN1_RST;
            open_ticks <= WIN2_RST;
        end else if (restart) begin
            seq <= wwdst_pkg::SEQ_RESTART;
            win_count <= 8'h00;
        end else begin
            unique case (seq)
                wwdst_pkg::SEQ_RESTART: begin
                    // Settings are sampled here, after any write of the same restart
                    first_window_ticks <= closed_window_length_reg;
                    open_ticks <= open_window_length_reg;
                    win_count <= 8'h00;
                    if (closed_window_length_reg == 7'h00) begin
                        seq <= wwdst_pkg::SEQ_OPEN;
                    end else begin
                        seq <= wwdst_pkg::SEQ_CLOSED;
                    end
                end
                wwdst_pkg::SEQ_CLOSED: begin
                    if (tick && win_count == {1'b0, first_window_ticks} - 8'h01) begin
                        seq <= wwdst_pkg::SEQ_OPEN;
                        win_count <= 8'h00;
                    end else if (tick) begin
                        win_count <= win_count + 8'h01;
                    end
                end
                wwdst_pkg::SEQ_OPEN: begin
                    if (tick) begin
                        win_count <= win_count + 8'h01;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // Watchdog flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags <= 2'h0;
        end else begin
            flags[`WWDST_FLAG_EARLY] <= bad || (flags[`WWDST_FLAG_EARLY]
                && !link.flag_clr[`WWDST_FLAG_EARLY]);
            flags[`WWDST_FLAG_TIMEOUT] <= (timeout && link.ncs_n) || (flags[`WWDST_FLAG_TIMEOUT]
                && !link.flag_clr[`WWDST_FLAG_TIMEOUT]);
        end
    end

    // ==========================================
    // Fail tally
    always_ff @(posedge clk_i) begin
        if (rst_i || diag_to_active_i) begin
            tally <= `WWDST_TALLY_INIT;
        end else if (bad || timeout || link.cfg_wr) begin
            if (tally != `WWDST_TALLY_MAX) begin
                tally <= tally + 3'h1;
            end
        end else if (good && tally != 3'h0) begin
            tally <= tally - 3'h1;
        end
    end

    // Reset request is one cycle wide; with the allow bit clear the tally just saturates
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            force_reset_o <= 1'b0;
        end else begin
            force_reset_o <= fail_reset_allow_i && tally == `WWDST_TALLY_MAX && (bad || timeout);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            good_event_o <= 1'b0;
            bad_event_o <= 1'b0;
            timeout_event_o <= 1'b0;
        end else begin
            good_event_o <= good;
            bad_event_o <= bad;
            timeout_event_o <= timeout;
        end
    end

    // Registered status; follows the tally one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_of_range_o <= 1'b1;
        end else begin
            out_of_range_o <= tally >= `WWDST_TALLY_INIT;
        end
    end

    assign link.watchdog_flag_reg = flags;
    assign link.fail_tally = tally;

endmodule

// >>> core/wwdst_host.sv
// Controller end: Wishbone registers driving triggers, window writes and frames
`timescale 1ns/1ps
`include "wwdst_map.svh"
module wwdst_host #(
    parameter int PULSE_CYC = `WWDST_PULSE_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Link to the watchdog
    wwdst_if.host link
);

    // ==========================================
    // Elaboration checks
    generate
        if (PULSE_CYC < 2 || PULSE_CYC > 65535) begin : g_bad_pulse
            $error("PULSE_CYC out of range");
        end
    endgenerate

    localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYC - 1);

    wwdst_pkg::wwdst_pulse_t pul;
    logic [15:0] pul_count;
    logic frame_hold;
    logic access;
    logic wr;

    assign access = cyc_i && stb_i && !ack_o;
    assign wr = access && we_i && sel_i[0];

    // ==========================================
    // Bus answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            dat_o <= 32'h0000_0000;
            if (access && !we_i) begin
                unique case (adr_i)
                    `WWDST_REG_STAT: dat_o <= {26'h0, pul != wwdst_pkg::PUL_IDLE,
                        link.fail_tally, link.watchdog_flag_reg};
                    `WWDST_REG_FRAME: dat_o <= {31'h0, frame_hold};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================
    // Window writes and flag clears, one cycle each
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link.cfg_wr <= 1'b0;
            link.cfg_sel <= 1'b0;
            link.cfg_data <= 7'h00;
            link.flag_clr <= 2'h0;
            frame_hold <= 1'b0;
        end else begin
            link.cfg_wr <= wr && (adr_i == `WWDST_REG_WIN1 || adr_i == `WWDST_REG_WIN2);
            link.flag_clr <= (wr && adr_i == `WWDST_REG_STAT) ? dat_i[1:0] : 2'h0;
            if (wr && (adr_i == `WWDST_REG_WIN1 || adr_i == `WWDST_REG_WIN2)) begin
                link.cfg_sel <= adr_i == `WWDST_REG_WIN2;
                link.cfg_data <= dat_i[6:0];
            end
            if (wr && adr_i == `WWDST_REG_FRAME) begin
                frame_hold <= dat_i[0];
            end
        end
    end

    // A window write is a serial frame, so chip select is low with it
    assign link.ncs_n = !(frame_hold || link.cfg_wr);

    // ==========================================
    // Trigger pulse: high then low, each longer than the filter time
    // Requests while a pulse is running are dropped; software polls the busy bit.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pul <= wwdst_pkg::PUL_IDLE;
            pul_count <= 16'h0000;
            link.fault_trigger_input <= 1'b0;
        end else begin
            unique case (pul)
                wwdst_pkg::PUL_IDLE: begin
                    if (wr && adr_i == `WWDST_REG_TRIG && dat_i[0]) begin
                        pul <= wwdst_pkg::PUL_HIGH;
                        pul_count <= 16'h0000;
                        link.fault_trigger_input <= 1'b1;
                    end
                end
                wwdst_pkg::PUL_HIGH: begin
                    if (pul_count == PULSE_LAST) begin
                        pul <= wwdst_pkg::PUL_LOW;
                        pul_count <= 16'h0000;
                        link.fault_trigger_input <= 1'b0;
                    end else begin
                        pul_count <= pul_count + 16'h0001;
                    end
                end
                wwdst_pkg::PUL_LOW: begin
                    if (pul_count == PULSE_LAST) begin
                        pul <= wwdst_pkg::PUL_IDLE;
                    end else begin
                        pul_count <= pul_count + 16'h0001;
                    end
                end
            endcase
        end
    end

endmodule

// >>> testbench/wwdst_monitor.sv
// Concurrent checks on the link between controller end and watchdog sequencer
`timescale 1ns/1ps
module wwdst_monitor #(
    parameter int PULSE_CYC = 400
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link signals
    input wire logic fault_trigger_input,
    input wire logic ncs_n,
    input wire logic cfg_wr,
    input wire logic [1:0] flag_clr,
    input wire logic [1:0] watchdog_flag_reg,
    input wire logic [2:0] fail_tally
);
    // ==========================================
    // Helper logic
    int hi_cnt;
    logic [2:0] tally_at_wr;

    always_ff @(posedge clk_i) begin
        if (rst_i || !fault_trigger_input) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= hi_cnt + 1;
        end
    end

    // Tally seen at a window write, so the later bump can be judged against it
    always_ff @(posedge clk_i) begin
        if (cfg_wr) begin
            tally_at_wr <= fail_tally;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_TALLY_RST: assert property (disable iff (1'b0) rst_i |=> fail_tally == 3'h5 && watchdog_flag_reg == 2'h0)
        else $error("tally or flags wrong after reset");
    AST_CFG_BUMP: assert property (cfg_wr && fail_tally != 3'h7 |-> ##[1:3] fail_tally == tally_at_wr + 3'h1)
        else $error("window write did not bump tally");
    AST_CFG_NCS: assert property (cfg_wr |-> !ncs_n)
        else $error("window write outside a frame");
    AST_EARLY_TALLY: assert property ($rose(watchdog_flag_reg[0]) |->
        fail_tally == (($past(fail_tally) == 3'h7) ? 3'h7 : $past(fail_tally) + 3'h1))
        else $error("early flag without tally bump");
    AST_TO_TALLY: assert property ($rose(watchdog_flag_reg[1]) |->
        fail_tally == (($past(fail_tally) == 3'h7) ? 3'h7 : $past(fail_tally) + 3'h1))
        else $error("timeout flag without tally bump");
    AST_TO_NCS: assert property ($rose(watchdog_flag_reg[1]) |-> $past(ncs_n))
        else $error("timeout flag latched during a frame");
    AST_CFG_SAT: assert property (cfg_wr && fail_tally == 3'h7 |=> fail_tally == 3'h7)
        else $error("tally moved past its ceiling on a window write");
    AST_EARLY_CLR: assert property ($fell(watchdog_flag_reg[0]) |-> $past(flag_clr[0]))
        else $error("early flag dropped without clear");
    AST_TO_CLR: assert property ($fell(watchdog_flag_reg[1]) |-> $past(flag_clr[1]))
        else $error("timeout flag dropped without clear");
    AST_PULSE_LEN: assert property ($fell(fault_trigger_input) |-> hi_cnt == PULSE_CYC)
        else $error("trigger high time wrong");

    C_EARLY: cover property ($rose(watchdog_flag_reg[0]));
    C_TIMEOUT: cover property ($rose(watchdog_flag_reg[1]));
    C_WRITE: cover property (cfg_wr && fail_tally == 3'h6);
endmodule

// >>> testbench/tb.sv
// Self-checking bench: controller end and watchdog sequencer joined by their link
`timescale 1ns/1ps
`include "wwdst_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic diag_state_i, diag_to_active_i, config_lock_command_i, fail_reset_allow_i, power_event_i;
    logic out_of_range_o, force_reset_o, good_event_o, bad_event_o, timeout_event_o;
    int miscompares = 0;
    int n_checks = 0;
    int n;
    wire [3:0] evts = {force_reset_o, timeout_event_o, bad_event_o, good_event_o};

    wwdst_if link();
    wwdst_host #(.PULSE_CYC(8)) u_wwdst_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .link(link.host));
    // Short tick and filter keep the run brief; all expected spans use 20 cycles a tick
    wwdst_device #(.TICK_CYC(20), .FILT_CYC(4)) u_wwdst_device (
        .clk_i(clk_i), .rst_i(rst_i), .link(link.dev), .diag_state_i(diag_state_i),
        .diag_to_active_i(diag_to_active_i), .config_lock_command_i(config_lock_command_i),
        .fail_reset_allow_i(fail_reset_allow_i), .power_event_i(power_event_i), .out_of_range_o(out_of_range_o),
        .force_reset_o(force_reset_o), .good_event_o(good_event_o), .bad_event_o(bad_event_o),
        .timeout_event_o(timeout_event_o));
    wwdst_monitor #(.PULSE_CYC(8)) u_wwdst_monitor (.clk_i(clk_i), .rst_i(rst_i),
        .fault_trigger_input(link.fault_trigger_input), .ncs_n(link.ncs_n), .cfg_wr(link.cfg_wr),
        .flag_clr(link.flag_clr), .watchdog_flag_reg(link.watchdog_flag_reg), .fail_tally(link.fail_tally));

    // ==========================================
    // Tasks
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task stat(input logic [4:0] mask, input logic [4:0] exp, input string nm);
        wb(1'b0, `WWDST_REG_STAT, 32'h0);
        `CHK(nm, exp, rd[4:0] & mask)
    endtask

    // Waits for an event pulse and judges how many cycles it took
    task wait_ev(input int b, input string nm, input int lo, input int hi);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (evts[b] !== 1'b1 && n < 2000);
        n_checks++;
        if (n < lo || n > hi) begin
            miscompares++;
            $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, n);
        end
    endtask

    task done(input string s);
        $display("test %s finished", s);
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ==========================================
    // Clock, watchdog and tests
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        #1000000;
        miscompares++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h0;
        diag_state_i = 1'b1;
        diag_to_active_i = 1'b0;
        config_lock_command_i = 1'b0;
        fail_reset_allow_i = 1'b0;
        power_event_i = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK("out_of_range", 1'b1, out_of_range_o)
        stat(5'h1F, 5'h14, "stat_reset");
        wb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_read", 32'h0, rd)
        done("reset");
        wb(1'b1, `WWDST_REG_TRIG, 32'h1);
        wait_ev(1, "bad_latency", 1, 60);
        stat(5'h1F, 5'h19, "stat_bad");
        done("early");
        // Lands the next trigger well inside the open window of the default timing
        repeat (240) @(posedge clk_i);
        wb(1'b1, `WWDST_REG_TRIG, 32'h1);
        wait_ev(0, "good_latency", 1, 60);
        stat(5'h1F, 5'h15, "stat_good");
        wb(1'b1, `WWDST_REG_STAT, 32'h3);
        stat(5'h1F, 5'h14, "stat_clear");
        done("good");
        // Restart cycle plus 16 ticks after the good event, less the nine cycles of three bus calls
        wait_ev(2, "timeout_span", 310, 314);
        stat(5'h1F, 5'h1A, "stat_timeout");
        wb(1'b1, `WWDST_REG_STAT, 32'h3);
        done("timeout");
        wb(1'b1, `WWDST_REG_WIN1, 32'h2);
        wb(1'b1, `WWDST_REG_WIN2, 32'h1);
        wait_ev(2, "short_span", 76, 88);
        stat(5'h1C, 5'h1C, "stat_sat");
        done("window_write");
        diag_to_active_i <= 1'b1;
        @(posedge clk_i);
        diag_to_active_i <= 1'b0;
        stat(5'h1C, 5'h14, "stat_reload");
        config_lock_command_i <= 1'b1;
        wb(1'b1, `WWDST_REG_WIN2, 32'h5);
        stat(5'h1C, 5'h18, "locked_bump");
        wait_ev(2, "locked_span", 70, 88);
        config_lock_command_i <= 1'b0;
        diag_state_i <= 1'b0;
        wb(1'b1, `WWDST_REG_WIN1, 32'h0A);
        wait_ev(2, "nondiag_span", 70, 90);
        diag_state_i <= 1'b1;
        done("lock");
        wb(1'b1, `WWDST_REG_STAT, 32'h3);
        wb(1'b1, `WWDST_REG_FRAME, 32'h1);
        wait_ev(2, "frame_timeout", 1, 90);
        stat(5'h1F, 5'h1C, "frame_hides_flag");
        wb(1'b1, `WWDST_REG_FRAME, 32'h0);
        wait_ev(2, "open_timeout", 1, 90);
        stat(5'h1F, 5'h1E, "flag_latched");
        done("frame");
        fail_reset_allow_i <= 1'b1;
        wait_ev(3, "force_reset", 1, 90);
        fail_reset_allow_i <= 1'b0;
        done("reset_on_fail");
        // Mid-sequence so a missed restart would time out far too soon
        repeat (40) @(posedge clk_i);
        power_event_i <= 1'b1;
        @(posedge clk_i);
        power_event_i <= 1'b0;
        wait_ev(2, "power_span", 70, 90);
        done("power");
        summarize();
    end
endmodule
